// File: rtl/dcr_pkg.sv
// package: register map, field layout, reset values and timing for dcdc regs
package dcr_pkg;
  // register byte addresses on the word-aligned bus
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h4;
  localparam logic [3:0] ADDR_ADC_CFG = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  // control register fields
  localparam int CTL_MIN_PULSE_SEL_LSB = 6;
  localparam int CTL_SWITCH_BIT = 5;
  localparam int CTL_RSVD_BIT = 4;
  localparam int CTL_SYNC_BIT = 3;
  localparam int CTL_VOUT_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'h21;
  // config register fields
  localparam int CFG_RSVD_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_POL_BIT = 4;
  localparam int CFG_INV_BIT = 3;
  localparam int CFG_ILIM_BIT = 2;
  localparam int CFG_SLP_BIT = 1;
  localparam int CFG_SRC_BIT = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h7F;
  // adc configuration shadow: sample clock field in bits 7:3
  localparam int ADC_SC_LSB = 3;
  localparam logic [7:0] ADC_RESET = 8'hF8;
  // minimum pulse widths in ns and as system clock cycles (round up)
  localparam int CLK_PERIOD_NS = 8;
  localparam int MIN_PULSE_SEL_1_NS = 20;
  localparam int MIN_PULSE_SEL_2_NS = 40;
  localparam int MIN_PULSE_SEL_3_NS = 80;
  localparam logic [7:0] MIN_PULSE_SEL_1_CYC =
    8'((MIN_PULSE_SEL_1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MIN_PULSE_SEL_2_CYC =
    8'((MIN_PULSE_SEL_2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MIN_PULSE_SEL_3_CYC =
    8'((MIN_PULSE_SEL_3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // output voltage targets in millivolts, indexed by code
  localparam logic [11:0] VOUT_MV [8] = '{12'h708, 12'h76C, 12'h7D0,
    12'h834, 12'h960, 12'hA8C, 12'hBB8, 12'hCE4};
endpackage : dcr_pkg

// File: rtl/dcr_clk_if.sv
// interface: divider settings toward the converter clock divider
`timescale 1ns/1ps
interface dcr_clk_if;
  logic [1:0] div_sel;
  logic invert;
  logic use_sysclk;
  logic tick;
  modport ctl (output div_sel, output invert, output use_sysclk,
    input tick);
  modport div (input div_sel, input invert, input use_sysclk, output tick);
endinterface : dcr_clk_if

// File: rtl/dcr_clk_div.sv
// converter clock divider: enable pulse at sysclk / 1, 2, 4 or 8
`timescale 1ns/1ps
module dcr_clk_div
  import dcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  dcr_clk_if.div cif
);
  logic [2:0] cnt;
  logic [2:0] lim;
  logic phase;

  always_comb begin
    lim = 3'((1 << cif.div_sel) - 1);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !cif.use_sysclk) begin
      cnt <= 3'h0;
    end else if (cnt >= lim) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // inversion shifts the tick by half a period of the divided clock, except at divide by 1 where it does not move
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      phase <= 1'b0;
    end else begin
      phase <= cif.invert;
    end
  end

  always_comb begin
    cif.tick = cif.use_sysclk &&
      (cnt == (phase ? 3'(lim >> 1) : lim));
  end
endmodule : dcr_clk_div

// File: rtl/dcr_regs.sv
// dcdc converter control and configuration registers on avalon-mm
`timescale 1ns/1ps
module dcr_regs
  import dcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic quiet_i,
  output logic [7:0] min_pulse_cyc_o,
  output logic switch_size_sel_o,
  output logic [2:0] out_voltage_sel_o,
  output logic [11:0] out_voltage_mv_o,
  output logic adc_sync_en_o,
  output logic adc_track_o,
  output logic adc_sar_clk_o,
  output logic conv_clk_tick_o,
  output logic conv_clk_source_o,
  output logic peak_limit_high_o,
  output logic sleep_float_o
);
  logic [7:0] ctl;
  logic [7:0] cfg;
  logic [7:0] adc_config_reg;
  logic done;
  logic quiet_s1;
  logic quiet_s2;
  logic sar_raw;
  logic [7:0] next_pw;
  dcr_clk_if cif ();

  dcr_clk_div u_div (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .cif(cif)
  );

  //////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, answer on the second edge
  wire req = avs_read_i || avs_write_i;
  // a write lands on the edge where the master sees waitrequest low
  wire wr_ok = avs_write_i && done && avs_byteenable_i[0];

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      done <= 1'b0;
    end else begin
      done <= req && !done;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(req && !done);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !done) begin
      unique case (avs_address_i)
        ADDR_CONTROL: avs_readdata_o <= {24'h000000, ctl};
        ADDR_CONFIG: avs_readdata_o <= {24'h000000, cfg};
        ADDR_ADC_CFG: avs_readdata_o <= {24'h000000, adc_config_reg};
        ADDR_STATUS: avs_readdata_o <= {29'h0, adc_sar_clk_o,
          adc_track_o, conv_clk_tick_o};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctl <= CTL_RESET;
    end else if (wr_ok && avs_address_i == ADDR_CONTROL) begin
      // bit 4 is stored as written; software keeps it zero
      ctl <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      cfg <= CFG_RESET;
    end else if (wr_ok && avs_address_i == ADDR_CONFIG) begin
      cfg <= avs_writedata_i[7:0] & CFG_WMASK;
    end
  end

  // adc configuration shadow; sample clock field must be zero under sync
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_config_reg <= ADC_RESET;
    end else if (wr_ok && avs_address_i == ADDR_ADC_CFG) begin
      adc_config_reg <= avs_writedata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // converter controls
  assign cif.div_sel = cfg[CFG_DIV_LSB +: 2];
  assign cif.invert = cfg[CFG_INV_BIT];
  assign cif.use_sysclk = cfg[CFG_SRC_BIT];

  always_comb begin
    unique case (ctl[CTL_MIN_PULSE_SEL_LSB +: 2])
      2'h0: next_pw = 8'h00;
      2'h1: next_pw = MIN_PULSE_SEL_1_CYC;
      2'h2: next_pw = MIN_PULSE_SEL_2_CYC;
      2'h3: next_pw = MIN_PULSE_SEL_3_CYC;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      min_pulse_cyc_o <= 8'h00;
    end else begin
      min_pulse_cyc_o <= next_pw;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      switch_size_sel_o <= CTL_RESET[CTL_SWITCH_BIT];
    end else begin
      switch_size_sel_o <= ctl[CTL_SWITCH_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      out_voltage_sel_o <= CTL_RESET[CTL_VOUT_LSB +: 3];
      out_voltage_mv_o <= VOUT_MV[CTL_RESET[CTL_VOUT_LSB +: 3]];
    end else begin
      out_voltage_sel_o <= ctl[CTL_VOUT_LSB +: 3];
      out_voltage_mv_o <= VOUT_MV[ctl[CTL_VOUT_LSB +: 3]];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_sync_en_o <= CTL_RESET[CTL_SYNC_BIT];
    end else begin
      adc_sync_en_o <= ctl[CTL_SYNC_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      conv_clk_source_o <= CFG_RESET[CFG_SRC_BIT];
    end else begin
      conv_clk_source_o <= cfg[CFG_SRC_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      peak_limit_high_o <= CFG_RESET[CFG_ILIM_BIT];
    end else begin
      peak_limit_high_o <= cfg[CFG_ILIM_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sleep_float_o <= CFG_RESET[CFG_SLP_BIT];
    end else begin
      sleep_float_o <= cfg[CFG_SLP_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      conv_clk_tick_o <= 1'b0;
    end else begin
      conv_clk_tick_o <= cif.tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // adc synchronisation: quiet interval from the analog side
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      quiet_s1 <= 1'b0;
      quiet_s2 <= 1'b0;
    end else begin
      quiet_s1 <= quiet_i;
      quiet_s2 <= quiet_s1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_track_o <= 1'b0;
    end else begin
      adc_track_o <= ctl[CTL_SYNC_BIT] && quiet_s2;
    end
  end

  // sar clock toggles on each converter tick while synced
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || !ctl[CTL_SYNC_BIT]) begin
      sar_raw <= 1'b0;
    end else if (cif.tick) begin
      sar_raw <= !sar_raw;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      adc_sar_clk_o <= 1'b0;
    end else if (!ctl[CTL_SYNC_BIT]) begin
      adc_sar_clk_o <= 1'b0;
    end else begin
      adc_sar_clk_o <= sar_raw ^ !cfg[CFG_POL_BIT];
    end
  end
endmodule : dcr_regs

// File: verification/dcr_regs_asserts.sv
// checker: bus timing and output relations of the dcdc register block
`timescale 1ns/1ps
module dcr_regs_asserts
  import dcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic quiet_i,
  input wire logic [7:0] min_pulse_cyc_o,
  input wire logic switch_size_sel_o,
  input wire logic [2:0] out_voltage_sel_o,
  input wire logic [11:0] out_voltage_mv_o,
  input wire logic adc_sync_en_o,
  input wire logic adc_track_o,
  input wire logic adc_sar_clk_o,
  input wire logic conv_clk_tick_o,
  input wire logic conv_clk_source_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_answer_next:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered");
  a_wait_one:
  assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_ctl_read:
  assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == ADDR_CONTROL |-> avs_readdata_o[5] ==
    switch_size_sel_o && avs_readdata_o[3] == adc_sync_en_o
    && avs_readdata_o[2:0] == out_voltage_sel_o)
    else $error("control read differs from outputs");
  a_volt_map:
  assert property ($stable(out_voltage_sel_o)
    |-> out_voltage_mv_o == VOUT_MV[out_voltage_sel_o])
    else $error("voltage target wrong");
  a_pulse_map:
  assert property (min_pulse_cyc_o inside {8'h00, 8'h03, 8'h05, 8'h0A})
    else $error("pulse width off table");
  a_track_quiet:
  assert property ((adc_sync_en_o && quiet_i)[*4] |-> adc_track_o)
    else $error("no tracking in quiet interval");
  a_sync_off:
  assert property ((!adc_sync_en_o)[*4] |-> !adc_track_o && !adc_sar_clk_o)
    else $error("adc activity without sync");
  a_src_off:
  assert property ((!conv_clk_source_o)[*2] |-> !conv_clk_tick_o)
    else $error("tick on local oscillator");
endmodule : dcr_regs_asserts
bind dcr_regs dcr_regs_asserts u_chk (.*);

// File: verification/dcr_regs_bench.sv
// bench: register access and output checks of the dcdc register block
`timescale 1ns/1ps
module dcr_regs_bench
  import dcr_pkg::*;
;
  logic ref_clk_i = 0, nrst_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic quiet_i = 0, avs_waitrequest_o, switch_size_sel_o, adc_sync_en_o;
  logic adc_track_o, adc_sar_clk_o, conv_clk_tick_o, conv_clk_source_o;
  logic peak_limit_high_o, sleep_float_o;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hF;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic [7:0] min_pulse_cyc_o, d;
  logic [7:0] pw [4] = '{8'h00, 8'h03, 8'h05, 8'h0A};
  logic [2:0] out_voltage_sel_o;
  logic [11:0] out_voltage_mv_o;
  int miscompares = 0, n_checks = 0, t, s;
  always #4 ref_clk_i = ~ref_clk_i;
  dcr_regs DUT (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] v, input logic [31:0] e);
    n_checks++;
    if (v !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, v};
    do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 99);
    q = avs_readdata_o;
    if (n >= 99) miscompares++;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : xfer
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    check(q, e);
  endtask : rchk
  // counts ticks and sar clock toggles over 64 cycles
  task automatic watch();
    logic p;
    repeat (3) @(posedge ref_clk_i);
    t = 0;
    s = 0;
    p = adc_sar_clk_o;
    repeat (64) begin
      @(posedge ref_clk_i);
      t += conv_clk_tick_o;
      s += (adc_sar_clk_o != p);
      p = adc_sar_clk_o;
    end
  endtask : watch
  task end_sim;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rchk(ADDR_CONTROL, 32'h21);
    rchk(ADDR_CONFIG, 32'h00);
    rchk(ADDR_ADC_CFG, 32'hF8);
    check(out_voltage_mv_o, 12'h76C);
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], i[0], 2'b00, i[2:0]};
      xfer(1'b1, ADDR_CONTROL, d);
      rchk(ADDR_CONTROL, {24'h0, d});
      check(min_pulse_cyc_o, pw[i[1:0]]);
      check(switch_size_sel_o, i[0]);
      check(out_voltage_mv_o, VOUT_MV[i]);
      check(out_voltage_sel_o, i[2:0]);
    end
    avs_byteenable_i <= 4'h0;
    xfer(1'b1, ADDR_CONTROL, 8'h00);
    avs_byteenable_i <= 4'hF;
    rchk(ADDR_CONTROL, 32'hE7);
    xfer(1'b1, 4'h2, 8'hFF);
    rchk(4'h2, 32'h00);
    xfer(1'b1, ADDR_CONFIG, 8'hFF);
    rchk(ADDR_CONFIG, 32'h7F);
    check({peak_limit_high_o, sleep_float_o, conv_clk_source_o}, 3'h7);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ADDR_CONFIG, {1'b0, k[1:0], 1'b1, k[0], 3'b001});
      watch();
      check(t, 64 >> k);
    end
    xfer(1'b1, ADDR_CONFIG, 8'h60);
    watch();
    check(t, 0);
    xfer(1'b1, ADDR_ADC_CFG, 8'h00);
    rchk(ADDR_ADC_CFG, 32'h00);
    xfer(1'b1, ADDR_CONFIG, 8'h01);
    xfer(1'b1, ADDR_CONTROL, 8'h29);
    quiet_i <= 1'b1;
    watch();
    check(adc_track_o, 1'b1);
    check(s, 64);
    check(adc_sync_en_o, 1'b1);
    quiet_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    check(adc_track_o, 1'b0);
    // no ticks under the local oscillator: sar clock rests at the inverse of the polarity bit
    xfer(1'b1, ADDR_CONTROL, 8'h21);
    xfer(1'b1, ADDR_CONFIG, 8'h00);
    xfer(1'b1, ADDR_CONTROL, 8'h29);
    repeat (3) @(posedge ref_clk_i);
    check(adc_sar_clk_o, 1'b1);
    xfer(1'b1, ADDR_CONFIG, 8'h10);
    repeat (3) @(posedge ref_clk_i);
    check(adc_sar_clk_o, 1'b0);
    xfer(1'b1, ADDR_CONTROL, 8'h21);
    watch();
    check(s, 0);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rchk(ADDR_CONFIG, 32'h00);
    end_sim();
  end
endmodule : dcr_regs_bench
